/* common/ddcc_pkg.sv */
// constants, field layout and carrier types of the downconverter chain
// assumes one 50 MHz clock and an apb master holding the map below
package ddcc_pkg;
  localparam int MANT_W = 15;
  localparam int X_W = 22;
  localparam int CIC_W = 68;
  localparam int ACC_W = 80;
  localparam int OUT_W = 21;
  localparam int COEF_W = 16;
  localparam int F1_TAPS = 21;
  localparam int F1_COEFS = 11;
  localparam int F2_TAPS = 63;
  localparam int F2_COEFS = 32;
  localparam int SCALE_BIAS = 44;
  localparam int FIR_SHIFT = 16;
  localparam logic [5:0] SCALE_MAX = 6'h28;
  localparam logic [2:0] EXP_MAX = 3'h7;
  localparam logic [10:0] RATIO_MIN = 11'h007;
  localparam logic [10:0] RATIO_RST = 11'h007;
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_RATIO = 12'h004;
  localparam logic [11:0] ADDR_SCALE = 12'h008;
  localparam logic [11:0] ADDR_BOOST = 12'h00c;
  localparam logic [11:0] ADDR_PH_A = 12'h010;
  localparam logic [11:0] ADDR_PH_B = 12'h014;
  localparam logic [11:0] ADDR_FREQ = 12'h018;
  localparam logic [11:0] ADDR_STAT = 12'h01c;
  localparam logic [3:0] F1_PAGE = 4'h1;
  localparam logic [3:0] F2_PAGE = 4'h2;
  localparam int CTRL_CHAN_A_PHASE_NOISE_ON = 0;
  localparam int CTRL_CHAN_B_PHASE_NOISE_ON = 1;
  localparam int CTRL_DVGA_OFF = 2;
  localparam int CTRL_F2_DEC4 = 3;
  localparam logic [3:0] CTRL_RST = 4'h3;
  localparam int BOOST_B_LSB = 4;
  localparam logic [15:0] LFSR_POLY = 16'hb400;
  localparam logic [15:0] SEED_A = 16'h0001;
  localparam logic [15:0] SEED_B = 16'h8000;
  localparam logic [1:0] F2_LAST_DEC2 = 2'h1;
  localparam logic [1:0] F2_LAST_DEC4 = 2'h3;
  typedef struct packed {
    logic valid;
    logic [MANT_W-1:0] mant;
    logic [2:0] expo;
  } ddcc_mix_t;
  typedef struct packed {
    logic valid;
    logic [OUT_W-1:0] data;
  } ddcc_smp_t;
endpackage

/* hw/ddcc_chain.sv */
// one channel: nco phase, cic decimator, boost, two decimating firs
// assumes mixer input on pclk, sync pin asynchronous, apb master
module ddcc_chain (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic sync_strobe_n,
  input wire ddcc_pkg::ddcc_mix_t mix_in,
  output logic [15:0] nco_phase_a,
  output logic [15:0] nco_phase_b,
  output ddcc_pkg::ddcc_smp_t chan_out
);
  import ddcc_pkg::*;

  function automatic logic [15:0] lfsr_step(input logic [15:0] s);
    lfsr_step = s[0] ? ((s >> 1) ^ LFSR_POLY) : (s >> 1);
  endfunction

  // saturate a wide value to the 21-bit output range
  function automatic logic [OUT_W-1:0] sat21(
    input logic signed [ACC_W-1:0] v);
    if (v[ACC_W-1:OUT_W-1] == {(ACC_W-OUT_W+1){v[ACC_W-1]}})
      sat21 = v[OUT_W-1:0];
    else
      sat21 = {v[ACC_W-1], {(OUT_W-1){~v[ACC_W-1]}}};
  endfunction

  // folded symmetric sum; index nt-1-i mirrors index i
  function automatic logic signed [ACC_W-1:0] fir_sum(
    input logic [F2_TAPS*OUT_W-1:0] s,
    input logic [F2_COEFS*COEF_W-1:0] c,
    input int nt);
    logic signed [ACC_W-1:0] acc;
    logic signed [OUT_W+1:0] pair;
    logic signed [OUT_W+COEF_W+1:0] prod;
    int h;
    acc = '0;
    h = nt / 2;
    for (int i = 0; i < F2_COEFS; i++) begin
      pair = '0;
      if (i < h)
        pair = $signed(s[i*OUT_W +: OUT_W])
          + $signed(s[(nt-1-i)*OUT_W +: OUT_W]);
      else if (i == h)
        pair = $signed(s[i*OUT_W +: OUT_W]);
      prod = pair * $signed(c[i*COEF_W +: COEF_W]);
      acc = acc + ACC_W'(prod);
    end
    fir_sum = acc;
  endfunction

  function automatic logic coef_hit(input logic [11:0] a,
    input logic [3:0] page, input int n);
    coef_hit = (a[11:8] == page) && (a[1:0] == 2'b00)
      && (a[7:2] < 6'(n));
  endfunction

  ////////////////////////////////////////////////////////////////////
  // sync pin filter
  logic s1_q, s2_q, s3_q, sync_lvl_q;
  logic sync_lvl_d, flush;
  always_comb begin
    sync_lvl_d = (s2_q == s3_q) ? s3_q : sync_lvl_q;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1_q <= 1'b1;
      s2_q <= 1'b1;
      s3_q <= 1'b1;
      sync_lvl_q <= 1'b1;
    end else begin
      s1_q <= sync_strobe_n;
      s2_q <= s1_q;
      s3_q <= s2_q;
      sync_lvl_q <= sync_lvl_d;
    end
  end
  assign flush = ~sync_lvl_q;

  ////////////////////////////////////////////////////////////////////
  // apb registers
  logic [3:0] ctrl_q, ctrl_d;
  logic [10:0] ratio_q, ratio_d;
  logic [5:0] scale_q, scale_d;
  logic [2:0] boost_a_q, boost_a_d, boost_b_q, boost_b_d;
  logic [15:0] ph_a_q, ph_a_d, ph_b_q, ph_b_d;
  logic [31:0] freq_q, freq_d;
  logic [F1_COEFS*COEF_W-1:0] c1_q, c1_d;
  logic [F2_COEFS*COEF_W-1:0] c2_q, c2_d;
  logic [31:0] rd_q, rd_d;
  logic err_q, err_d;
  logic [10:0] cnt_q;
  logic [15:0] ocnt_q;
  logic wr, setup;
  assign wr = psel & penable & pwrite;
  assign setup = psel & ~penable;
  assign pready = 1'b1;
  assign prdata = rd_q;
  assign pslverr = err_q;
  always_comb begin
    ctrl_d = ctrl_q;
    ratio_d = ratio_q;
    scale_d = scale_q;
    boost_a_d = boost_a_q;
    boost_b_d = boost_b_q;
    ph_a_d = ph_a_q;
    ph_b_d = ph_b_q;
    freq_d = freq_q;
    c1_d = c1_q;
    c2_d = c2_q;
    rd_d = rd_q;
    err_d = err_q;
    if (wr) begin
      case (paddr)
        ADDR_CTRL: ctrl_d = pwdata[3:0];
        ADDR_RATIO: ratio_d = (pwdata[10:0] < RATIO_MIN) ?
          RATIO_MIN : pwdata[10:0];
        ADDR_SCALE: scale_d = (pwdata[5:0] > SCALE_MAX) ?
          SCALE_MAX : pwdata[5:0];
        ADDR_BOOST: begin
          boost_a_d = pwdata[2:0];
          boost_b_d = pwdata[BOOST_B_LSB +: 3];
        end
        ADDR_PH_A: ph_a_d = pwdata[15:0];
        ADDR_PH_B: ph_b_d = pwdata[15:0];
        ADDR_FREQ: freq_d = pwdata;
        default: begin
          // only the unique first_fir coefs stored
          if (coef_hit(paddr, F1_PAGE, F1_COEFS))
            c1_d[paddr[7:2]*COEF_W +: COEF_W] = pwdata[15:0];
          // only the unique second_fir coefs stored
          if (coef_hit(paddr, F2_PAGE, F2_COEFS))
            c2_d[paddr[7:2]*COEF_W +: COEF_W] = pwdata[15:0];
        end
      endcase
    end
    if (setup) begin
      err_d = 1'b0;
      rd_d = '0;
      case (paddr)
        ADDR_CTRL: rd_d = {28'h0, ctrl_q};
        ADDR_RATIO: rd_d = {21'h0, ratio_q};
        ADDR_SCALE: rd_d = {26'h0, scale_q};
        ADDR_BOOST: rd_d = {25'h0, boost_b_q, 1'b0, boost_a_q};
        ADDR_PH_A: rd_d = {16'h0, ph_a_q};
        ADDR_PH_B: rd_d = {16'h0, ph_b_q};
        ADDR_FREQ: rd_d = freq_q;
        ADDR_STAT: rd_d = {ocnt_q, 5'h0, cnt_q};
        default: begin
          if (coef_hit(paddr, F1_PAGE, F1_COEFS))
            rd_d = {16'h0, c1_q[paddr[7:2]*COEF_W +: COEF_W]};
          else if (coef_hit(paddr, F2_PAGE, F2_COEFS))
            rd_d = {16'h0, c2_q[paddr[7:2]*COEF_W +: COEF_W]};
          else
            err_d = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_q <= CTRL_RST;
      ratio_q <= RATIO_RST;
      scale_q <= '0;
      boost_a_q <= '0;
      boost_b_q <= '0;
      ph_a_q <= '0;
      ph_b_q <= '0;
      freq_q <= '0;
      c1_q <= '0;
      c2_q <= '0;
      rd_q <= '0;
      err_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      ratio_q <= ratio_d;
      scale_q <= scale_d;
      boost_a_q <= boost_a_d;
      boost_b_q <= boost_b_d;
      ph_a_q <= ph_a_d;
      ph_b_q <= ph_b_d;
      freq_q <= freq_d;
      c1_q <= c1_d;
      c2_q <= c2_d;
      rd_q <= rd_d;
      err_q <= err_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // nco phase with dither
  logic [31:0] acc_q, acc_d, dpa, dpb;
  logic [15:0] lfa_q, lfa_d, lfb_q, lfb_d, pa_d, pb_d;
  always_comb begin
    acc_d = acc_q + freq_q;
    lfa_d = lfsr_step(lfa_q);
    lfb_d = lfsr_step(lfb_q);
    // dither lands in the truncated bits
    dpa = acc_q + {16'h0, ctrl_q[CTRL_CHAN_A_PHASE_NOISE_ON] ? lfa_q : 16'h0};
    dpb = acc_q + {16'h0, ctrl_q[CTRL_CHAN_B_PHASE_NOISE_ON] ? lfb_q : 16'h0};
    pa_d = dpa[31:16] + ph_a_q;
    pb_d = dpb[31:16] + ph_b_q;
    // phase and dither restart on sync
    if (flush) begin
      acc_d = '0;
      lfa_d = SEED_A;
      lfb_d = SEED_B;
      pa_d = ph_a_q;
      pb_d = ph_b_q;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_q <= '0;
      lfa_q <= SEED_A;
      lfb_q <= SEED_B;
      nco_phase_a <= '0;
      nco_phase_b <= '0;
    end else begin
      acc_q <= acc_d;
      lfa_q <= lfa_d;
      lfb_q <= lfb_d;
      nco_phase_a <= pa_d;
      nco_phase_b <= pb_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // float to fixed, cic, boost
  logic signed [CIC_W-1:0] int_q [4];
  logic signed [CIC_W-1:0] int_d [4];
  logic signed [CIC_W-1:0] dly_q [4];
  logic signed [CIC_W-1:0] dly_d [4];
  logic signed [CIC_W-1:0] cy;
  logic signed [X_W-1:0] x3;
  logic signed [ACC_W-1:0] bv;
  logic [2:0] ex;
  logic [10:0] cnt_d;
  logic dec_hit;
  ddcc_smp_t bst_q, bst_d;
  always_comb begin
    // exponent forced to max when compensation off
    ex = ctrl_q[CTRL_DVGA_OFF] ? EXP_MAX : mix_in.expo;
    x3 = X_W'($signed(mix_in.mant)) <<< ex;
    dec_hit = mix_in.valid && (cnt_q == ratio_q);
    cnt_d = mix_in.valid ? (dec_hit ? 11'h0 : cnt_q + 11'h1) : cnt_q;
    int_d = int_q;
    dly_d = dly_q;
    cy = int_q[3];
    bst_d = '{valid: 1'b0, data: bst_q.data};
    bv = '0;
    if (mix_in.valid) begin
      // headroom shift, the 2^-44 is applied after the combs
      int_d[0] = int_q[0] + (CIC_W'(x3) <<< scale_q);
      for (int k = 1; k < 4; k++)
        int_d[k] = int_q[k] + int_d[k-1];
    end
    // gain N^4 * 2^(scale-44) is unity only for power-of-two N
    for (int k = 0; k < 4; k++) begin
      if (dec_hit)
        dly_d[k] = cy;
      cy = cy - dly_q[k];
    end
    if (dec_hit) begin
      bv = ACC_W'(cy) <<< boost_a_q;
      bv = bv + (ACC_W'(1) <<< SCALE_BIAS);
      // rounding 22 bits to 21 supplies the mixer half
      // shift by boost then round to 21 bits
      bst_d = '{valid: 1'b1, data: sat21(bv >>> (SCALE_BIAS + 1))};
    end
    if (flush) begin
      cnt_d = '0;
      for (int k = 0; k < 4; k++) begin
        int_d[k] = '0;
        dly_d[k] = '0;
      end
      bst_d = '0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_q <= '0;
      int_q <= '{default: '0};
      dly_q <= '{default: '0};
      bst_q <= '0;
    end else begin
      cnt_q <= cnt_d;
      int_q <= int_d;
      dly_q <= dly_d;
      bst_q <= bst_d;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // first_fir and second_fir
  logic [F1_TAPS*OUT_W-1:0] t1_q, t1_d;
  logic [F2_TAPS*OUT_W-1:0] t2_q, t2_d;
  logic ph1_q, ph1_d;
  logic [1:0] ph2_q, ph2_d, last2;
  logic [15:0] ocnt_d;
  ddcc_smp_t f1_q, f1_d, out_d;
  always_comb begin
    t1_d = t1_q;
    t2_d = t2_q;
    ph1_d = ph1_q;
    ph2_d = ph2_q;
    ocnt_d = ocnt_q;
    last2 = ctrl_q[CTRL_F2_DEC4] ? F2_LAST_DEC4 : F2_LAST_DEC2;
    f1_d = '{valid: 1'b0, data: f1_q.data};
    out_d = '{valid: 1'b0, data: chan_out.data};
    // accept only on the upstream strobe
    if (bst_q.valid) begin
      t1_d = {t1_q[(F1_TAPS-1)*OUT_W-1:0], bst_q.data};
      ph1_d = ~ph1_q;
      if (ph1_q) begin
        f1_d = '{valid: 1'b1, data: sat21(fir_sum(
          {{(F2_TAPS-F1_TAPS)*OUT_W{1'b0}}, t1_d},
          {{(F2_COEFS-F1_COEFS)*COEF_W{1'b0}}, c1_q},
          F1_TAPS) >>> FIR_SHIFT)};
      end
    end
    if (f1_q.valid) begin
      t2_d = {t2_q[(F2_TAPS-1)*OUT_W-1:0], f1_q.data};
      ph2_d = (ph2_q == last2) ? 2'h0 : ph2_q + 2'h1;
      if (ph2_q == last2) begin
        ocnt_d = ocnt_q + 16'h1;
        // latency set by fir half lengths and decimation
        out_d = '{valid: 1'b1,
          data: sat21(fir_sum(t2_d, c2_q, F2_TAPS) >>> FIR_SHIFT)};
      end
    end
    if (flush) begin
      t1_d = '0;
      t2_d = '0;
      ph1_d = 1'b0;
      ph2_d = '0;
      f1_d = '0;
      out_d = '0;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      t1_q <= '0;
      t2_q <= '0;
      ph1_q <= 1'b0;
      ph2_q <= '0;
      ocnt_q <= '0;
      f1_q <= '0;
      chan_out <= '0;
    end else begin
      t1_q <= t1_d;
      t2_q <= t2_d;
      ph1_q <= ph1_d;
      ph2_q <= ph2_d;
      ocnt_q <= ocnt_d;
      f1_q <= f1_d;
      chan_out <= out_d;
    end
  end
endmodule // ddcc_chain

/* test/ddcc_chain_properties.sv */
// port checker for the downconverter chain
// assumes one clock domain; bound into ddcc_chain at the foot
module ddcc_chain_properties (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic sync_strobe_n,
  input wire ddcc_pkg::ddcc_mix_t mix_in,
  input wire logic [15:0] nco_phase_a,
  input wire logic [15:0] nco_phase_b,
  input wire ddcc_pkg::ddcc_smp_t chan_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import ddcc_pkg::*;
  logic [7:0] gap_q;
  logic [3:0] sync_age_q;
  logic [3:0] wr_age_q;
  logic sync_last_q;
  logic [15:0] off_a_q;
  logic [15:0] off_b_q;
  logic [31:0] freq_q;
  logic wr_now;
  logic ok_addr;
  assign wr_now = psel && penable && pwrite && pready;
  assign ok_addr = paddr[1:0] == 2'h0 && (paddr <= ADDR_STAT ||
    (paddr >= 12'h100 && paddr <= 12'h128) ||
    (paddr >= 12'h200 && paddr <= 12'h27c));
  //////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gap_q <= 8'hff;
      sync_age_q <= 4'h0;
      wr_age_q <= 4'h0;
      sync_last_q <= 1'b1;
      off_a_q <= 16'h0;
      off_b_q <= 16'h0;
      freq_q <= 32'h0;
    end else begin
      gap_q <= chan_out.valid ? 8'h0 : gap_q + 8'(gap_q != 8'hff);
      sync_last_q <= sync_strobe_n;
      sync_age_q <= (sync_strobe_n != sync_last_q) ? 4'h0 :
        sync_age_q + 4'(sync_age_q != 4'hf);
      wr_age_q <= wr_now ? 4'h0 : wr_age_q + 4'(wr_age_q != 4'hf);
      if (wr_now && paddr == ADDR_PH_A) begin
        off_a_q <= pwdata[15:0];
      end
      if (wr_now && paddr == ADDR_PH_B) begin
        off_b_q <= pwdata[15:0];
      end
      if (wr_now && paddr == ADDR_FREQ) begin
        freq_q <= pwdata;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_strobe_once: assert property (chan_out.valid |=> !chan_out.valid)
    else $error("output strobe lasted more than one cycle");
  a_out_spacing: assert property (chan_out.valid |-> gap_q >= 8'd31)
    else $error("outputs closer than the least decimation");
  a_data_holds: assert property (!chan_out.valid && sync_age_q >= 4'd8
    |-> $stable(chan_out.data)) else $error("output data moved");
  a_sync_quiet: assert property (!sync_strobe_n && sync_age_q >= 4'd6
    |-> !chan_out.valid) else $error("output during sync");
  a_phase_a: assert property (freq_q == 0 && wr_age_q >= 4'd4
    && sync_strobe_n |-> nco_phase_a == off_a_q)
    else $error("channel a phase differs from offset");
  a_phase_b: assert property (freq_q == 0 && wr_age_q >= 4'd4
    && sync_strobe_n |-> nco_phase_b == off_b_q)
    else $error("channel b phase differs from offset");
  a_unmapped_err: assert property (psel && penable && !ok_addr
    |-> pslverr) else $error("unmapped access without error");
  a_mapped_ok: assert property (psel && penable && ok_addr
    |-> !pslverr && pready) else $error("mapped access refused");
  c_output: cover property (chan_out.valid);
  c_sync_held: cover property (!sync_strobe_n && sync_age_q == 4'hf);
  c_refused: cover property (psel && penable && pslverr);
endmodule // ddcc_chain_properties

bind ddcc_chain ddcc_chain_properties ddcc_chain_properties_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .sync_strobe_n(sync_strobe_n),
  .mix_in(mix_in), .nco_phase_a(nco_phase_a), .nco_phase_b(nco_phase_b),
  .chan_out(chan_out));

/* test/ddcc_mixer_model.sv */
// upstream mixer stand-in: one sample a clock, or every other clock
// assumes the chain takes mix_out at each rising edge with valid
module ddcc_mixer_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic run,
  input wire logic sparse,
  input wire logic [14:0] mant,
  input wire logic [2:0] expo,
  output ddcc_pkg::ddcc_mix_t mix_out
);
  timeunit 1ns;
  timeprecision 1ns;
  import ddcc_pkg::*;
  logic alt_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mix_out <= '0;
      alt_q <= 1'b0;
    end else begin
      alt_q <= ~alt_q;
      if (run && (!sparse || alt_q)) begin
        mix_out <= '{valid: 1'b1, mant: mant, expo: expo};
      end else begin
        // idle fields toggle so stale values are never trusted
        mix_out.valid <= 1'b0;
        mix_out.mant <= ~mix_out.mant;
        mix_out.expo <= ~mix_out.expo;
      end
    end
  end
endmodule // ddcc_mixer_model

/* test/ddcc_chain_test.sv */
// self-checking bench for the downconverter chain
// drives apb and the mixer model; checks registers and samples
module ddcc_chain_test;
  timeunit 1ns;
  timeprecision 1ns;
  import ddcc_pkg::*;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic sync_strobe_n = 1, run = 0, sparse = 0, pready, pslverr, err;
  logic [11:0] paddr = 0;
  logic [31:0] pwdata = 0, prdata, rd;
  logic [15:0] nco_phase_a, nco_phase_b, ph;
  logic [14:0] mant = 0;
  logic [2:0] expo = 0;
  ddcc_mix_t mix_in;
  ddcc_smp_t chan_out;
  int n_errors = 0, checks = 0, n_out = 0, cyc = 0, last = 0, seed = 63;
  int diff = 0;
  logic [20:0] exp_data[$];
  int exp_gap[$];
  int t_code[6] = '{7, 7, 7, 7, 7, 15};
  int t_scale[6] = '{33, 33, 33, 33, 33, 29};
  int t_mant[6] = '{1024, 1024, 512, 16383, -16384, 1024};
  int t_expo[6] = '{0, 0, 1, 2, 0, 0};
  int t_ctrl[6] = '{3, 11, 3, 7, 15, 3};
  int t_boost[6] = '{0, 0, 0, 7, 7, 2};
  int t_f1[6] = '{10, 0, 10, 10, 10, 10};
  int t_f2[6] = '{31, 0, 0, 31, 31, 31};
  int t_exp[6] = '{64, 256, 128, 65535, -65536, 256};
  ddcc_chain ddcc_chain_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sync_strobe_n(sync_strobe_n), .mix_in(mix_in),
    .nco_phase_a(nco_phase_a), .nco_phase_b(nco_phase_b),
    .chan_out(chan_out));
  ddcc_mixer_model ddcc_mixer_model_i (.pclk(pclk), .presetn(presetn),
    .run(run), .sparse(sparse), .mant(mant), .expo(expo), .mix_out(mix_in));
  initial begin
    forever #10 pclk = ~pclk;
  end
  //////////////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d n_errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_smp(input logic [20:0] g, input logic [20:0] e);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value at %0t: sample %h want %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge so the next setup never overwrites this release
    @(posedge pclk);
  endtask
  task automatic wait_out(input int n, input int d, input int g);
    int target;
    target = n_out + n;
    while (n_out < target) @(posedge pclk);
    repeat (3) begin
      exp_data.push_back(21'(d));
      exp_gap.push_back(g);
    end
    while (exp_data.size() > 0) @(posedge pclk);
  endtask
  //////////////////////////////////////////////////////////////////////
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc > 80000) begin
      n_errors++;
      complete_run();
    end
    if (chan_out.valid === 1'b1) begin
      n_out <= n_out + 1;
      last <= cyc;
      if (exp_data.size() > 0) begin
        chk_smp(chan_out.data, exp_data.pop_front());
        chk(32'(cyc - last), 32'(exp_gap.pop_front()));
      end
    end
  end
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(ADDR_CTRL, 0, 0);
    chk(rd, 32'h3);
    apb(ADDR_RATIO, 1, 32'h2);
    apb(ADDR_RATIO, 0, 0);
    chk(rd, 32'h7);
    apb(ADDR_SCALE, 1, 32'h3f);
    apb(ADDR_SCALE, 0, 0);
    chk(rd, 32'h28);
    apb(12'h040, 0, 0);
    chk({31'h0, err}, 32'h1);
    apb(12'h300, 1, 32'h1);
    chk({31'h0, err}, 32'h1);
    repeat (4) begin
      ph = 16'($random(seed));
      apb(ADDR_PH_A, 1, {16'hffff, ph});
      apb(ADDR_PH_B, 1, {16'h0, ~ph});
      apb(ADDR_PH_A, 0, 0);
      chk(rd, {16'h0, ph});
      repeat (4) @(posedge pclk);
      chk({16'h0, nco_phase_a ^ nco_phase_b}, 32'hffff);
    end
    // the two channels part only when one channel's dither is switched on
    apb(ADDR_FREQ, 1, 32'h00008000);
    for (int m = 0; m < 3; m++) begin
      apb(ADDR_CTRL, 1, 32'(m));
      diff = 0;
      repeat (64) begin
        @(posedge pclk);
        if (16'(nco_phase_a - ph) != 16'(nco_phase_b - ~ph)) begin
          diff++;
        end
      end
      chk({31'h0, diff != 0}, {31'h0, m != 0});
    end
    // step cleared under sync so the accumulator restarts at zero
    sync_strobe_n <= 1'b0;
    apb(ADDR_FREQ, 1, 32'h0);
    for (int i = 0; i < 6; i++) begin
      sync_strobe_n <= 1'b0;
      apb(ADDR_CTRL, 1, 32'(t_ctrl[i]));
      apb(ADDR_RATIO, 1, 32'(t_code[i]));
      apb(ADDR_SCALE, 1, 32'(t_scale[i]));
      apb(ADDR_BOOST, 1, 32'(t_boost[i] * 17));
      for (int k = 0; k < 32; k++) begin
        if (k < F1_COEFS) begin
          apb(12'(256 + 4 * k), 1, k == t_f1[i] ? 32'h4000 : 32'h0);
        end
        apb(12'(512 + 4 * k), 1, k == t_f2[i] ? 32'h4000 : 32'h0);
      end
      apb(ADDR_RATIO, 0, 0);
      chk(rd, 32'(t_code[i]));
      mant <= 15'(t_mant[i]);
      expo <= 3'(t_expo[i]);
      sparse <= (i == 2);
      run <= 1'b1;
      sync_strobe_n <= 1'b1;
      wait_out(40, t_exp[i], (t_code[i] + 1) * ((t_ctrl[i] & 8) ? 8 : 4)
        * ((i == 2) ? 2 : 1));
    end
    complete_run();
  end
endmodule // ddcc_chain_test
